// [shared/eeprom_tb_pkg.sv]
// Package with register map, field positions, reset values and timing constants
package eeprom_tb_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned PGM_MAX_US      = 500;
  localparam int unsigned ERASE_MAX_MS    = 8;
  localparam int unsigned PGM_MAX_CYC     = (CLK_HZ / 1000000) * PGM_MAX_US;
  localparam int unsigned ERASE_MAX_CYC   = (CLK_HZ / 1000) * ERASE_MAX_MS;
  // Ticks of the time base used by automatic timing (default prescale gives 1 us ticks)
  localparam logic [15:0] AUTO_PGM_TICKS   = 16'h0190;
  localparam logic [15:0] AUTO_ERASE_TICKS = 16'h1770;

  // ****************************************
  // Register byte addresses (one byte each)
  // ****************************************
  localparam logic [15:0] ADDR_MASK_OPT_B = 16'hfe09;
  localparam logic [15:0] ADDR_DIVH_1     = 16'hfe1a;
  localparam logic [15:0] ADDR_DIVL_1     = 16'hfe1b;
  localparam logic [15:0] ADDR_ACFG_1     = 16'hfe1f;
  localparam logic [15:0] ADDR_CTRL_1     = 16'hfe1d;
  localparam logic [15:0] ADDR_DIVH_2     = 16'hff7a;
  localparam logic [15:0] ADDR_DIVL_2     = 16'hff7b;
  localparam logic [15:0] ADDR_ACFG_2     = 16'hff7f;
  localparam logic [15:0] ADDR_CTRL_2     = 16'hff7d;
  localparam logic [15:0] ADDR_IRQ_STAT   = 16'hfe40;
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'hfe44;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned MOB_CLKSEL_BIT  = 7;
  localparam int unsigned MOB_MONPROT_BIT = 4;
  localparam int unsigned MOB_REV_BIT     = 3;
  localparam int unsigned CTRL_PGM_BIT    = 0;
  localparam int unsigned CTRL_AUTO_BIT   = 1;
  localparam int unsigned CTRL_ERASE_BIT  = 2;
  localparam int unsigned CTRL_LEGACY_BIT = 7;
  localparam int unsigned DIV_W           = 11;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] MOB_RESET        = 8'h08;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET   = 2'h0;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [7:0]       acfg;
  } nv_copy_s;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_MANUAL,
    OP_AUTO
  } op_state_e;

endpackage : eeprom_tb_pkg

// [hdl/eeprom_timebase.sv]
// Two-array EEPROM time base, automatic program/erase timing and APB registers
// Operation
// - Programmed cells read 0, erased cells read 1.
// - Automatic program completes within 500 us.
// - Automatic erase completes within 8 ms.
// - Mask option B bit 7 selects the time-base reference clock.
// - Each divider divides by an 11-bit prescale plus one, split over high/low registers.
// - Divider registers reload from non-volatile copies at every reset.
// - Array configuration reloads from non-volatile copy at reset.
// - Control register bit 7 has no function.
// - Control register bit 1 enables automatic timing.
// - Automatic mode chooses the program or erase duration itself.
// - Software sets program enable and polls; device clears it when an automatic operation is done.
// - Mask option B bit 3 is a fixed revision bit, read only.
// - Mask option B bit 4 blocks array reads in monitor mode.
//
// The APB interface to the registers is this design's own decision.
module eeprom_timebase
  import eeprom_tb_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [15:0]  paddr_i,
  input  wire logic [31:0]  pwdata_i,
  input  wire logic [3:0]   pstrb_i,
  output logic      [31:0]  prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  input  wire nv_copy_s     nv_copy_1_i,
  input  wire nv_copy_s     nv_copy_2_i,
  input  wire logic         ref_clk_alt_en_i,
  input  wire logic         monitor_mode_i,
  input  wire logic         array_rd_req_i,
  output logic              array_rd_block_o,
  output logic [1:0]        hv_program_o,
  output logic [1:0]        hv_erase_o,
  output logic [1:0]        timebase_tick_o,
  output logic              irq_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]       mob_ff,   nxt_mob;
  logic [DIV_W-1:0] div_ff   [2];
  logic [DIV_W-1:0] nxt_div  [2];
  logic [7:0]       acfg_ff  [2];
  logic [7:0]       nxt_acfg [2];
  logic [7:0]       ctrl_ff  [2];
  logic [7:0]       nxt_ctrl [2];
  logic [1:0]       stat_ff,  nxt_stat;
  logic [1:0]       mask_ff,  nxt_mask;
  logic             load_ff,  nxt_load;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic             err_ff,   nxt_err;

  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd_mux;
  logic [1:0]  done;
  nv_copy_s    nv [2];

  assign nv[0] = nv_copy_1_i;
  assign nv[1] = nv_copy_2_i;
  assign acc   = psel_i & penable_i;
  // A write lands only at the edge where ready is high, never in the reload cycle
  assign wr    = acc & pwrite_i & pstrb_i[0] & ~load_ff;

  // Reference clock selection: internal bus rate or qualified alternate
  logic ref_en;
  assign ref_en = mob_ff[MOB_CLKSEL_BIT] ? ref_clk_alt_en_i : 1'b1;

  // ****************************************
  // Per-array divider and automatic timer
  // ****************************************
  logic [1:0] pgm_en;
  generate
    for (genvar a = 0; a < 2; a++) begin : g_arr
      logic [DIV_W-1:0] cnt_ff,   nxt_cnt;
      logic [15:0]      ticks_ff, nxt_ticks;
      logic [23:0]      guard_ff, nxt_guard;
      op_state_e        st_ff,    nxt_st;
      logic             tick;
      logic             fin;
      logic [15:0]      limit;
      logic [23:0]      glimit;

      assign pgm_en[a] = ctrl_ff[a][CTRL_PGM_BIT];
      assign tick      = ref_en & (cnt_ff == '0);
      assign limit     = ctrl_ff[a][CTRL_ERASE_BIT] ? AUTO_ERASE_TICKS : AUTO_PGM_TICKS;
      assign glimit    = ctrl_ff[a][CTRL_ERASE_BIT] ? 24'(ERASE_MAX_CYC - 1)
                                                    : 24'(PGM_MAX_CYC - 1);
      // Completion by tick count, or by cycle guard so the bound holds for any prescale
      assign fin       = (ticks_ff >= limit) | (guard_ff >= glimit);
      assign done[a]   = (st_ff == OP_AUTO) & fin;

      // Time base: counts down at the reference rate, reloads from the prescale at zero
      always_comb begin
        nxt_cnt = cnt_ff;
        if (ref_en) begin
          nxt_cnt = (cnt_ff == '0) ? div_ff[a] : cnt_ff - 1'b1;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_ff <= '0;
        end else begin
          cnt_ff <= nxt_cnt;
        end
      end

      // Operation timer: counts time-base ticks, with a cycle guard as backstop
      always_comb begin
        nxt_ticks = ticks_ff;
        nxt_guard = guard_ff;
        nxt_st    = st_ff;
        unique case (st_ff)
          OP_IDLE: begin
            nxt_ticks = '0;
            nxt_guard = '0;
            if (pgm_en[a]) begin
              nxt_st = ctrl_ff[a][CTRL_AUTO_BIT] ? OP_AUTO : OP_MANUAL;
            end
          end
          OP_MANUAL: begin
            if (!pgm_en[a]) begin
              nxt_st = OP_IDLE;
            end
          end
          OP_AUTO: begin
            nxt_guard = guard_ff + 24'h000001;
            if (tick) begin
              nxt_ticks = ticks_ff + 16'h0001;
            end
            if (fin || !pgm_en[a]) begin
              nxt_st = OP_IDLE;
            end
          end
        endcase
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          ticks_ff <= '0;
          guard_ff <= '0;
          st_ff    <= OP_IDLE;
        end else begin
          ticks_ff <= nxt_ticks;
          guard_ff <= nxt_guard;
          st_ff    <= nxt_st;
        end
      end

      assign timebase_tick_o[a] = tick;
      assign hv_program_o[a] = (st_ff != OP_IDLE) & ~ctrl_ff[a][CTRL_ERASE_BIT];
      assign hv_erase_o[a]   = (st_ff != OP_IDLE) & ctrl_ff[a][CTRL_ERASE_BIT];
    end
  endgenerate

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd_mux = '0;
    hit    = 1'b1;
    unique case (paddr_i)
      ADDR_MASK_OPT_B: rd_mux[7:0] = mob_ff;
      ADDR_DIVH_1:     rd_mux[2:0] = div_ff[0][10:8];
      ADDR_DIVL_1:     rd_mux[7:0] = div_ff[0][7:0];
      ADDR_ACFG_1:     rd_mux[7:0] = acfg_ff[0];
      ADDR_CTRL_1:     rd_mux[7:0] = ctrl_ff[0] & 8'h7f;
      ADDR_DIVH_2:     rd_mux[2:0] = div_ff[1][10:8];
      ADDR_DIVL_2:     rd_mux[7:0] = div_ff[1][7:0];
      ADDR_ACFG_2:     rd_mux[7:0] = acfg_ff[1];
      ADDR_CTRL_2:     rd_mux[7:0] = ctrl_ff[1] & 8'h7f;
      ADDR_IRQ_STAT:   rd_mux[1:0] = stat_ff;
      ADDR_IRQ_MASK:   rd_mux[1:0] = mask_ff;
      default:         hit = 1'b0;
    endcase
  end

  // ****************************************
  // Register write and reload
  // ****************************************
  always_comb begin
    nxt_mob   = mob_ff;
    nxt_div   = div_ff;
    nxt_acfg  = acfg_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_load  = 1'b0;
    if (load_ff) begin
      for (int a = 0; a < 2; a++) begin
        nxt_div[a]  = nv[a].div;
        nxt_acfg[a] = nv[a].acfg;
      end
    end
    if (wr && hit) begin
      unique case (paddr_i)
        ADDR_MASK_OPT_B: begin
          nxt_mob[MOB_CLKSEL_BIT]  = pwdata_i[MOB_CLKSEL_BIT];
          nxt_mob[MOB_MONPROT_BIT] = pwdata_i[MOB_MONPROT_BIT];
        end
        ADDR_DIVH_1:   nxt_div[0][10:8] = pwdata_i[2:0];
        ADDR_DIVL_1:   nxt_div[0][7:0]  = pwdata_i[7:0];
        ADDR_ACFG_1:   nxt_acfg[0]      = pwdata_i[7:0];
        ADDR_CTRL_1:   nxt_ctrl[0]      = {1'b0, pwdata_i[6:0]};
        ADDR_DIVH_2:   nxt_div[1][10:8] = pwdata_i[2:0];
        ADDR_DIVL_2:   nxt_div[1][7:0]  = pwdata_i[7:0];
        ADDR_ACFG_2:   nxt_acfg[1]      = pwdata_i[7:0];
        ADDR_CTRL_2:   nxt_ctrl[1]      = {1'b0, pwdata_i[6:0]};
        default:       ;
      endcase
    end
    nxt_mob[MOB_REV_BIT] = 1'b1;
    for (int a = 0; a < 2; a++) begin
      if (done[a]) begin
        nxt_ctrl[a][CTRL_PGM_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mob_ff   <= MOB_RESET;
      div_ff   <= '{default: '0};
      acfg_ff  <= '{default: '0};
      ctrl_ff  <= '{default: CTRL_RESET};
      load_ff  <= 1'b1;
    end else begin
      mob_ff   <= nxt_mob;
      div_ff   <= nxt_div;
      acfg_ff  <= nxt_acfg;
      ctrl_ff  <= nxt_ctrl;
      load_ff  <= nxt_load;
    end
  end

  // ****************************************
  // Completion status and interrupt mask
  // ****************************************
  always_comb begin
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    if (wr && (paddr_i == ADDR_IRQ_STAT)) begin
      nxt_stat = stat_ff & ~pwdata_i[1:0];
    end
    if (wr && (paddr_i == ADDR_IRQ_MASK)) begin
      nxt_mask = pwdata_i[1:0];
    end
    // Completion event wins over a simultaneous clear
    nxt_stat = nxt_stat | done;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_ff <= '0;
      mask_ff <= IRQ_MASK_RESET;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  // ****************************************
  // Bus response
  // ****************************************
  // Read data and error are taken in the setup cycle and stand through the access
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err   = 1'b0;
    if (psel_i && !penable_i) begin
      nxt_rdata = pwrite_i ? 32'h0000_0000 : rd_mux;
      nxt_err   = ~hit;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
      err_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Ready is held off during the one-cycle reload after reset
  assign pready_o  = ~load_ff;
  assign prdata_o  = rdata_ff;
  assign pslverr_o = err_ff & acc;
  assign irq_o     = |(stat_ff & mask_ff);
  // Array data sense (programmed 0, erased 1) is outside; only access is gated here
  assign array_rd_block_o = array_rd_req_i & monitor_mode_i & mob_ff[MOB_MONPROT_BIT];

endmodule : eeprom_timebase

// [testbench/eeprom_timebase_properties.sv]
// Checker: port-level properties of the EEPROM time-base block
module eeprom_timebase_properties
  import eeprom_tb_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire nv_copy_s    nv_copy_1_i,
  input wire nv_copy_s    nv_copy_2_i,
  input wire logic        ref_clk_alt_en_i,
  input wire logic        monitor_mode_i,
  input wire logic        array_rd_req_i,
  input wire logic        array_rd_block_o,
  input wire logic [1:0]  hv_program_o,
  input wire logic [1:0]  hv_erase_o,
  input wire logic [1:0]  timebase_tick_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic wr1;
  assign acc = psel_i && penable_i && pready_o;
  assign wr1 = acc && pwrite_i && pstrb_i[0] && paddr_i == ADDR_CTRL_1;
  // ****************************************
  // Assertions and covers
  // ****************************************
  rd_block_a: assert property (array_rd_block_o |-> array_rd_req_i && monitor_mode_i)
    else $error("read block outside monitor mode read");
  rd_free_a: assert property (!array_rd_req_i |-> !array_rd_block_o)
    else $error("read block without a read request");
  rev_bit_a: assert property (acc && !pwrite_i && paddr_i == ADDR_MASK_OPT_B |-> prdata_o[3])
    else $error("revision bit reads zero");
  legacy_zero_a: assert property (acc && !pwrite_i && (paddr_i == ADDR_CTRL_1 ||
    paddr_i == ADDR_CTRL_2) |-> !prdata_o[CTRL_LEGACY_BIT]) else $error("control bit 7 reads one");
  op_start_a: assert property (wr1 && pwdata_i[0] |-> ##[1:3] (hv_program_o[0] || hv_erase_o[0]))
    else $error("operation did not start");
  op_stop_a: assert property (wr1 && !pwdata_i[0] |-> ##[1:3] !(hv_program_o[0] || hv_erase_o[0]))
    else $error("operation did not stop");
  irq_mask_a: assert property (acc && pwrite_i && pstrb_i[0] && paddr_i == ADDR_IRQ_MASK &&
    pwdata_i[1:0] == 2'h0 |=> !irq_o) else $error("masked interrupt still high");
  rst_idle_a: assert property ($fell(rst_i) |-> hv_program_o == 2'h0 && hv_erase_o == 2'h0)
    else $error("high voltage active after reset");
  cover property (wr1 && pwdata_i[1:0] == 2'h3);
  cover property ($rose(irq_o));
  cover property (array_rd_block_o);
endmodule : eeprom_timebase_properties

bind eeprom_timebase eeprom_timebase_properties eeprom_timebase_properties_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .nv_copy_1_i(nv_copy_1_i), .nv_copy_2_i(nv_copy_2_i), .ref_clk_alt_en_i(ref_clk_alt_en_i),
  .monitor_mode_i(monitor_mode_i), .array_rd_req_i(array_rd_req_i),
  .array_rd_block_o(array_rd_block_o), .hv_program_o(hv_program_o), .hv_erase_o(hv_erase_o),
  .timebase_tick_o(timebase_tick_o), .irq_o(irq_o));

// [testbench/tb_eeprom_timebase.sv]
// Testbench: registers, time base, automatic timing, interrupt and read protection
module tb_eeprom_timebase
  import eeprom_tb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        psel_i = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i = 1'h0;
  logic [15:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [3:0]  pstrb_i = 4'hf;
  logic        ref_clk_alt_en_i = 1'h0;
  logic        monitor_mode_i = 1'h0;
  logic        array_rd_req_i = 1'h0;
  nv_copy_s    nv_copy_1_i = '{div: 11'h018, acfg: 8'h5a};
  nv_copy_s    nv_copy_2_i = '{div: 11'h003, acfg: 8'ha5};
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, array_rd_block_o, irq_o;
  logic [1:0]  hv_program_o, hv_erase_o, timebase_tick_o;
  logic [31:0] r;
  logic        e;
  int          fails = 0, comparisons = 0, n, c1, c2;
  // Minimum hold of a manual program or erase: 10 ms of core cycles
  localparam int unsigned MIN_HOLD_CYC = (CLK_HZ / 1000) * 10;

  eeprom_timebase eeprom_timebase_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .nv_copy_1_i(nv_copy_1_i), .nv_copy_2_i(nv_copy_2_i), .ref_clk_alt_en_i(ref_clk_alt_en_i),
    .monitor_mode_i(monitor_mode_i), .array_rd_req_i(array_rd_req_i),
    .array_rd_block_o(array_rd_block_o), .hv_program_o(hv_program_o), .hv_erase_o(hv_erase_o),
    .timebase_tick_o(timebase_tick_o), .irq_o(irq_o));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready_o !== 1'h1 && k < 50);
    if (pready_o !== 1'h1) fails++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb

  task automatic do_reset();
    rst_i <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'h0;
  endtask : do_reset

  task automatic ticks();
    c1 = 0;
    c2 = 0;
    repeat (8) @(negedge core_clk_i);
    repeat (100) begin
      @(negedge core_clk_i);
      c1 += int'(timebase_tick_o[0] === 1'h1);
      c2 += int'(timebase_tick_o[1] === 1'h1);
    end
  endtask : ticks

  task automatic op(input logic [15:0] a, input logic [31:0] d, input int b);
    repeat (2500) @(posedge core_clk_i);
    apb(1'h1, a, d);
    n = 0;
    repeat (3) @(negedge core_clk_i);
    while ((hv_program_o[b] | hv_erase_o[b]) === 1'h1 && n < 250000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask : op

  task automatic end_sim();
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    apb(1'h0, ADDR_MASK_OPT_B, '0);
    chk(r[7:0], MOB_RESET);
    apb(1'h0, ADDR_DIVL_1, '0);
    chk(r[7:0], 8'h18);
    apb(1'h0, ADDR_ACFG_2, '0);
    chk(r[7:0], 8'ha5);
    apb(1'h0, ADDR_IRQ_MASK, '0);
    chk(r[1:0], IRQ_MASK_RESET);
    apb(1'h0, 16'hfe00, '0);
    chk(e, 1'h1);
    chk(r, 32'h0);
  endtask : t_reset_values

  task automatic t_timebase();
    ticks();
    chk(c1 * 256 + c2, 32'h0419);
    apb(1'h1, ADDR_MASK_OPT_B, 32'h80);
    ticks();
    chk(c1 + c2, 32'h0);
    ref_clk_alt_en_i <= 1'h1;
    ticks();
    chk(c1 * 256 + c2, 32'h0419);
  endtask : t_timebase

  task automatic t_protect();
    apb(1'h1, ADDR_MASK_OPT_B, 32'h10);
    apb(1'h0, ADDR_MASK_OPT_B, '0);
    chk(r[7:0], 8'h18);
    monitor_mode_i <= 1'h1;
    array_rd_req_i <= 1'h1;
    @(negedge core_clk_i);
    chk(array_rd_block_o, 1'h1);
    @(posedge core_clk_i);
    monitor_mode_i <= 1'h0;
    @(negedge core_clk_i);
    chk(array_rd_block_o, 1'h0);
    apb(1'h1, ADDR_CTRL_1, 32'h80);
    apb(1'h0, ADDR_CTRL_1, '0);
    chk(r[7:0], CTRL_RESET);
  endtask : t_protect

  task automatic t_auto();
    op(ADDR_CTRL_1, 32'h03, 0);
    chk(n >= 9900 && n <= PGM_MAX_CYC, 1'h1);
    apb(1'h0, ADDR_CTRL_1, '0);
    chk(r[0], 1'h0);
    chk(irq_o, 1'h0);
    apb(1'h1, ADDR_IRQ_MASK, 32'h3);
    @(negedge core_clk_i);
    chk(irq_o, 1'h1);
    apb(1'h1, ADDR_IRQ_STAT, 32'h1);
    @(negedge core_clk_i);
    chk(irq_o, 1'h0);
    op(ADDR_CTRL_2, 32'h07, 1);
    chk(n >= 23900 && n <= ERASE_MAX_CYC, 1'h1);
    chk(irq_o, 1'h1);
    apb(1'h1, ADDR_IRQ_MASK, 32'h0);
    apb(1'h1, ADDR_DIVH_1, 32'h7);
    apb(1'h1, ADDR_DIVL_1, 32'hff);
    op(ADDR_CTRL_1, 32'h03, 0);
    chk(n >= 12000 && n <= PGM_MAX_CYC, 1'h1);
  endtask : t_auto

  task automatic t_manual_reload();
    repeat (2500) @(posedge core_clk_i);
    apb(1'h1, ADDR_CTRL_1, 32'h01);
    apb(1'h1, ADDR_CTRL_2, 32'h05);
    repeat (MIN_HOLD_CYC) @(negedge core_clk_i);
    chk(hv_program_o, 2'h1);
    chk(hv_erase_o, 2'h2);
    apb(1'h1, ADDR_CTRL_1, 32'h00);
    apb(1'h1, ADDR_CTRL_2, 32'h00);
    repeat (3) @(negedge core_clk_i);
    chk({hv_program_o, hv_erase_o}, 4'h0);
    apb(1'h1, ADDR_ACFG_1, 32'h33);
    do_reset();
    apb(1'h0, ADDR_DIVL_1, '0);
    chk(r[7:0], 8'h18);
    apb(1'h0, ADDR_DIVH_1, '0);
    chk(r[2:0], 3'h0);
    apb(1'h0, ADDR_ACFG_1, '0);
    chk(r[7:0], 8'h5a);
  endtask : t_manual_reload

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  initial begin
    #16000000;
    fails++;
    end_sim();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_timebase();
    t_protect();
    t_auto();
    t_manual_reload();
    end_sim();
  end
endmodule : tb_eeprom_timebase
